// *** rtl/cpes_defs.svh ***
/*
  Constants for the core performance event selector: event codes, unit masks,
  configuration register offsets and field positions, reset values.
  Assumes it is included by its bare name from files under rtl/.
*/
`ifndef CPES_DEFS_SVH
`define CPES_DEFS_SVH

// ****************************************************************
// Event codes
// ****************************************************************
`define CPES_EV_CACHE_LOCK   8'h63
`define CPES_EV_IO_XACT      8'h6c
`define CPES_EV_ICACHE       8'h80
`define CPES_EV_BIG_XLATE    8'h82
`define CPES_EV_XLATE_MISS   8'h85
`define CPES_EV_LEN_STALL    8'h87
`define CPES_EV_BR_EXEC      8'h88
`define CPES_EV_BR_MISP      8'h89
`define CPES_EV_RES_STALL    8'ha2
`define CPES_EV_FUSED        8'ha6
`define CPES_EV_REDIRECT     8'ha7
`define CPES_EV_LOOP_REPLAY  8'ha8
`define CPES_EV_XLATE_FLUSH  8'hae
`define CPES_EV_UNCORE_WB    8'hb0
`define CPES_EV_PORT_OPS     8'hb1

// ****************************************************************
// Unit masks
// ****************************************************************
`define CPES_UM_01           8'h01
`define CPES_UM_02           8'h02
`define CPES_UM_03           8'h03
`define CPES_UM_04           8'h04
`define CPES_UM_08           8'h08
`define CPES_UM_0F           8'h0f
`define CPES_UM_40           8'h40
`define CPES_UM_1F           8'h1f
`define CPES_UM_3F           8'h3f
`define CPES_BR_CLASS_MASK   8'h7f

// ****************************************************************
// Register map (word offsets, word index on the bus)
// ****************************************************************
`define CPES_NUM_CTR         4
`define CPES_REG_STRIDE      4
`define CPES_OFF_SEL         2'h0
`define CPES_OFF_COUNT_LO    2'h1
`define CPES_OFF_COUNT_HI    2'h2
`define CPES_OFF_STATUS      2'h3
`define CPES_ADDR_W          4

// Select register fields.
`define CPES_SEL_EVENT_LSB   0
`define CPES_SEL_UMASK_LSB   8
`define CPES_SEL_EDGE_BIT    18
`define CPES_SEL_EN_BIT      22
`define CPES_SEL_INV_BIT     23
`define CPES_SEL_CMASK_LSB   24
`define CPES_SEL_RESET       32'h0000_0000
`define CPES_CNT_W           48
`define CPES_INC_W           4

`endif

// *** rtl/cpes_event_selector.sv ***
/*
  Core performance event selector: four programmable counters, each picking one
  event by event code and unit mask and adding its per-cycle occurrence count; counters 2 and 3 hold still on lock events.
  Assumes event sources run on CLK and present one-cycle pulses or levels, and that
  software reaches the select and count registers over Avalon-MM.
*/
`timescale 1ns/1ps
`include "cpes_defs.svh"

module cpes_event_selector
  import cpes_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        LOCK_UNCACHEABLE,
  input  wire logic        LOCK_SPLIT_LINE,
  input  wire logic        LOCK_UNCACHED_WALK,
  input  wire logic        DATA_LINE_LOCKED,
  input  wire logic        IO_DONE,
  input  wire logic        ICACHE_HIT,
  input  wire logic        ICACHE_MISS,
  input  wire logic        ICACHE_BYPASS_FETCH,
  input  wire logic        FETCH_STALL,
  input  wire logic        BIG_XLATE_HIT,
  input  wire logic        XLATE_WALK_START,
  input  wire logic        XLATE_WALK_DONE,
  input  wire logic [3:0]  LEN_STALL_CAUSE,
  input  wire logic        BR_EXEC,
  input  wire logic        BR_MISP,
  input  wire logic [6:0]  BR_CLASS,
  input  wire logic [7:0]  RES_STALL_CAUSE,
  input  wire logic        STORE_BUFS_FULL,
  input  wire logic        STORE_COMMIT,
  input  wire logic        FUSED_DECODE,
  input  wire logic        FORCED_REDIRECT,
  input  wire logic [2:0]  LOOP_REPLAY_OPS,
  input  wire logic        XLATE_FLUSH,
  input  wire logic        UNCORE_WB,
  input  wire logic [5:0]  PORT_OP,
  output logic             STORE_STALL,
  output logic [3:0]       COUNTER_ACTIVE
);

  // ****************************************************************
  // Event conditioning
  // ****************************************************************
  logic       dual_lock;
  logic       store_stall;
  logic [2:0] core_port_ops;
  logic       miss_seen;

  // The combined lock is the union of the three locking causes.
  assign dual_lock = LOCK_UNCACHEABLE | LOCK_SPLIT_LINE | LOCK_UNCACHED_WALK;

  // Store stall starts when all buffers fill and ends on a commit; commit wins.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      store_stall <= 1'b0;
    end else if (STORE_COMMIT) begin
      store_stall <= 1'b0;
    end else if (STORE_BUFS_FULL) begin
      store_stall <= 1'b1;
    end
  end

  // A miss held high for several cycles is counted only on its first cycle under unit mask 02.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      miss_seen <= 1'b0;
    end else begin
      miss_seen <= ICACHE_MISS;
    end
  end

  // Ports 2..4 come from a shared core source, so they are never split by thread.
  assign core_port_ops = PORT_OP[4:2];

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      STORE_STALL <= 1'b0;
    end else begin
      STORE_STALL <= store_stall;
    end
  end

  // ****************************************************************
  // Per-counter selection and counting
  // ****************************************************************
  logic [31:0]            sel   [`CPES_NUM_CTR];
  logic [`CPES_CNT_W-1:0] count [`CPES_NUM_CTR];
  logic [3:0]             active;

  genvar g;
  generate
    for (g = 0; g < `CPES_NUM_CTR; g = g + 1) begin : gen_ctr
      logic [7:0]             ev;
      logic [7:0]             um;
      logic [7:0]             cmask;
      logic                   inv;
      logic                   edge_en;
      logic                   en;
      logic [`CPES_INC_W-1:0] raw;
      logic [`CPES_INC_W-1:0] next_inc;
      logic                   thr_hit;
      logic                   prev_thr;
      logic                   low_only;
      logic                   act;

      assign ev      = sel[g][`CPES_SEL_EVENT_LSB +: 8];
      assign um      = sel[g][`CPES_SEL_UMASK_LSB +: 8];
      assign cmask   = sel[g][`CPES_SEL_CMASK_LSB +: 8];
      assign inv     = sel[g][`CPES_SEL_INV_BIT];
      assign edge_en = sel[g][`CPES_SEL_EDGE_BIT];
      assign en      = sel[g][`CPES_SEL_EN_BIT];
      assign low_only = (ev == `CPES_EV_CACHE_LOCK);

      // Decode the selection into this cycle's raw occurrence count.
      always_comb begin
        raw = '0;
        unique case (ev)
          `CPES_EV_CACHE_LOCK: begin
            if (um == `CPES_UM_01) raw = {3'h0, dual_lock};
            if (um == `CPES_UM_02) raw = {3'h0, DATA_LINE_LOCKED};
          end
          `CPES_EV_IO_XACT: begin
            if (um == `CPES_UM_01) raw = {3'h0, IO_DONE};
          end
          `CPES_EV_ICACHE: begin
            if (um == `CPES_UM_01) raw = {3'h0, ICACHE_HIT};
            if (um == `CPES_UM_02) raw = {3'h0, ICACHE_MISS & ~miss_seen};
            if (um == `CPES_UM_03) raw = {3'h0, ICACHE_HIT | ICACHE_MISS | ICACHE_BYPASS_FETCH};
            if (um == `CPES_UM_04) raw = {3'h0, FETCH_STALL};
          end
          `CPES_EV_BIG_XLATE: begin
            if (um == `CPES_UM_01) raw = {3'h0, BIG_XLATE_HIT};
          end
          `CPES_EV_XLATE_MISS: begin
            if (um == `CPES_UM_01) raw = {3'h0, XLATE_WALK_START};
            if (um == `CPES_UM_02) raw = {3'h0, XLATE_WALK_DONE};
          end
          `CPES_EV_LEN_STALL: begin
            raw = {3'h0, |(LEN_STALL_CAUSE & um[3:0])};
          end
          `CPES_EV_BR_EXEC: begin
            raw = {3'h0, BR_EXEC & |(BR_CLASS & um[6:0])};
          end
          `CPES_EV_BR_MISP: begin
            // Direct classes cannot mispredict; they are masked out for good.
            raw = {3'h0, BR_MISP & |(BR_CLASS & um[6:0] & 7'h6d)};
          end
          `CPES_EV_RES_STALL: begin
            raw = {3'h0, |({RES_STALL_CAUSE[7:4], store_stall, RES_STALL_CAUSE[2:0]} & um)};
          end
          `CPES_EV_FUSED: begin
            if (um == `CPES_UM_01) raw = {3'h0, FUSED_DECODE};
          end
          `CPES_EV_REDIRECT: begin
            if (um == `CPES_UM_01) raw = {3'h0, FORCED_REDIRECT};
          end
          `CPES_EV_LOOP_REPLAY: begin
            if (um == `CPES_UM_01) raw = {1'b0, LOOP_REPLAY_OPS};
          end
          `CPES_EV_XLATE_FLUSH: begin
            if (um == `CPES_UM_01) raw = {3'h0, XLATE_FLUSH};
          end
          `CPES_EV_UNCORE_WB: begin
            if (um == `CPES_UM_40) raw = {3'h0, UNCORE_WB};
          end
          `CPES_EV_PORT_OPS: begin
            // Weighted count is the number of selected ports busy this cycle.
            raw = 4'(PORT_OP[0] & um[0]) + 4'(PORT_OP[1] & um[1]) + 4'(core_port_ops[0] & um[2]) +
                  4'(core_port_ops[1] & um[3]) + 4'(core_port_ops[2] & um[4]) + 4'(PORT_OP[5] & um[5]);
          end
          default: raw = '0;
        endcase
      end

      // Threshold, inversion and edge shape the count as the selector fields ask.
      assign thr_hit = inv ? ({4'h0, raw} < cmask) : ({4'h0, raw} >= cmask);

      always_comb begin
        if (cmask == 8'h00) begin
          next_inc = raw;
        end else if (edge_en) begin
          next_inc = {3'h0, thr_hit & ~prev_thr};
        end else begin
          next_inc = {3'h0, thr_hit};
        end
      end

      always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
          prev_thr <= 1'b0;
        end else begin
          prev_thr <= thr_hit;
        end
      end

      // Lock events on counters above 1 hold the count still.
      always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
          count[g] <= '0;
        end else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 4'(g * 4 + 1)) begin
          count[g][31:0] <= AVS_WRITEDATA;
        end else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 4'(g * 4 + 2)) begin
          count[g][47:32] <= AVS_WRITEDATA[15:0];
        end else if (en && !(low_only && g > 1)) begin
          count[g] <= count[g] + {44'h0, next_inc};
        end
      end

      // Each counter keeps its own activity flop so the shared vector has one driver per bit.
      always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
          act <= 1'b0;
        end else begin
          act <= en && !(low_only && g > 1) && (next_inc != '0);
        end
      end

      assign active[g] = act;

      // Select register write with byte enables.
      always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
          sel[g] <= `CPES_SEL_RESET;
        end else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 4'(g * 4)) begin
          for (int b = 0; b < 4; b++) begin
            if (AVS_BYTEENABLE[b]) sel[g][b*8 +: 8] <= AVS_WRITEDATA[b*8 +: 8];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      COUNTER_ACTIVE <= 4'h0;
    end else begin
      COUNTER_ACTIVE <= active;
    end
  end

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************
  cpes_bus_t bus_state;
  logic [1:0] ctr_idx;
  logic [1:0] reg_idx;

  assign ctr_idx = AVS_ADDRESS[3:2];
  assign reg_idx = AVS_ADDRESS[1:0];

  // Waitrequest drops for one cycle after a request is seen, so every access takes two cycles.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      bus_state       <= CPES_BUS_IDLE;
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      unique case (bus_state)
        CPES_BUS_IDLE: begin
          if (AVS_READ || AVS_WRITE) begin
            bus_state       <= CPES_BUS_DONE;
            AVS_WAITREQUEST <= 1'b0;
          end
        end
        CPES_BUS_DONE: begin
          bus_state       <= CPES_BUS_IDLE;
          AVS_WAITREQUEST <= 1'b1;
        end
      endcase
    end
  end

  // Read data is registered while waitrequest is still high, so it stands at the taking edge.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      AVS_READDATA <= 32'h0;
    end else if (AVS_READ && bus_state == CPES_BUS_IDLE) begin
      unique case (reg_idx)
        `CPES_OFF_SEL:      AVS_READDATA <= sel[ctr_idx];
        `CPES_OFF_COUNT_LO: AVS_READDATA <= count[ctr_idx][31:0];
        `CPES_OFF_COUNT_HI: AVS_READDATA <= {16'h0, count[ctr_idx][47:32]};
        `CPES_OFF_STATUS:   AVS_READDATA <= {30'h0, store_stall, active[ctr_idx]};
      endcase
    end
  end

endmodule // cpes_event_selector

// *** rtl/cpes_pkg.sv ***
/*
  Types shared by the core performance event selector.
  Assumes the constants header is compiled alongside.
*/
package cpes_pkg;
  typedef enum logic [0:0] {
    CPES_BUS_IDLE = 1'b0,
    CPES_BUS_DONE = 1'b1
  } cpes_bus_t;
endpackage

// *** test/cpes_checker.sv ***
/*
  Checker for the event selector: bus handshake and store stall timing.
  Assumes it is bound to the selector and sees only the selector's ports.
*/
`timescale 1ns/1ps

// ********************
// Checker
// ********************
module cpes_checker (
  input wire logic        CLK,
  input wire logic        RESETN,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        STORE_BUFS_FULL,
  input wire logic        STORE_COMMIT,
  input wire logic        STORE_STALL
);
  // Every check runs on the core clock and is quiet during reset.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // A request seen while waiting is answered at the next edge, for one cycle only.
  chk_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request not answered in one cycle");
  chk_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  chk_wait_cause: assert property (!AVS_WAITREQUEST |-> $past(AVS_READ) || $past(AVS_WRITE))
    else $error("waitrequest low without request");
  // Read data must stay put between reads, since a master may take it late.
  chk_read_hold: assert property (!(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA))
    else $error("read data moved outside a read");
  // The stall output lags the internal stall state by one cycle.
  chk_stall_set: assert property (STORE_BUFS_FULL && !STORE_COMMIT |=> ##1 STORE_STALL)
    else $error("store stall not raised");
  chk_stall_clear: assert property (STORE_COMMIT |=> ##1 !STORE_STALL)
    else $error("store stall not ended by commit");
  chk_stall_keep: assert property (!STORE_BUFS_FULL && !STORE_COMMIT |=> ##1 $stable(STORE_STALL))
    else $error("store stall changed with no cause");
  chk_stall_rise: assert property ($rose(STORE_STALL) |-> $past(STORE_BUFS_FULL, 2))
    else $error("store stall rose without full buffers");
endmodule // cpes_checker

bind cpes_event_selector cpes_checker u_chk (.CLK(CLK), .RESETN(RESETN), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .STORE_BUFS_FULL(STORE_BUFS_FULL), .STORE_COMMIT(STORE_COMMIT), .STORE_STALL(STORE_STALL));

// *** test/cpes_event_src.sv ***
/*
  Event source model standing for the pipeline and cache logic.
  Assumes the bench pulses fire for one cycle and holds vec through the burst.
*/
`timescale 1ns/1ps

// ********************
// Event source
// ********************
module cpes_event_src (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        fire,
  input  wire logic [47:0] vec,
  output logic      [47:0] ev
);
  logic [1:0] left;

  // A burst shows vec for two cycles, so a held miss must still count once.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      left <= 2'h0;
    end else if (fire) begin
      left <= 2'h2;
    end else if (left != 2'h0) begin
      left <= left - 2'h1;
    end
  end

  // Between bursts a store commits each cycle, so no store stall outlives its burst.
  assign ev = (left != 2'h0) ? vec : 48'h4_0000_0000;
endmodule // cpes_event_src

// *** test/tb.sv ***
/*
  Bench for the event selector: programs counters over Avalon-MM, fires bursts
  from the event source model and reads counts back against a queue of notes.
  Assumes the selector, checker and event source model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end

// ********************
// Bench
// ********************
module tb;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] e;
  logic        wait_req;
  logic        stall;
  logic [3:0]  active;
  logic [47:0] ev;
  logic [47:0] vec = 48'h0;
  logic [47:0] b = 48'h1;
  logic        fire = 1'b0;
  logic [31:0] exp_q[$];
  int          mismatches = 0;
  int          check_count = 0;
  int          tno = 0;
  int          seed;

  cpes_event_selector u_dut (.CLK(clk), .RESETN(resetn), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
    .LOCK_UNCACHEABLE(ev[0]), .LOCK_SPLIT_LINE(ev[1]), .LOCK_UNCACHED_WALK(ev[2]), .DATA_LINE_LOCKED(ev[3]),
    .IO_DONE(ev[4]), .ICACHE_HIT(ev[5]), .ICACHE_MISS(ev[6]), .ICACHE_BYPASS_FETCH(ev[7]), .FETCH_STALL(ev[8]),
    .BIG_XLATE_HIT(ev[9]), .XLATE_WALK_START(ev[10]), .XLATE_WALK_DONE(ev[11]), .LEN_STALL_CAUSE(ev[15:12]),
    .BR_EXEC(ev[16]), .BR_MISP(ev[17]), .BR_CLASS(ev[24:18]), .RES_STALL_CAUSE(ev[32:25]),
    .STORE_BUFS_FULL(ev[33]), .STORE_COMMIT(ev[34]), .FUSED_DECODE(ev[35]), .FORCED_REDIRECT(ev[36]),
    .LOOP_REPLAY_OPS(ev[39:37]), .XLATE_FLUSH(ev[40]), .UNCORE_WB(ev[41]), .PORT_OP(ev[47:42]),
    .STORE_STALL(stall), .COUNTER_ACTIVE(active));
  cpes_event_src u_src (.CLK(clk), .RESETN(resetn), .fire(fire), .vec(vec), .ev(ev));

  // Free-running 40 MHz core clock.
  initial begin
    forever #12.5 clk = ~clk;
  end

  // Each accepted read retires the oldest note; read data stands from the edge before it until the next read.
  always @(posedge clk) begin
    if (rd === 1'b1 && wait_req === 1'b0) begin
      e = exp_q.pop_front();
      `CHK("AVS_READDATA", e, rdata)
    end
  end

  // One Avalon access, held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do begin @(posedge clk); end while (wait_req !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [3:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    bus(1'b0, a, 32'h0);
  endtask

  // Preset a count, enable the selection, fire n bursts, disable, then read back.
  task automatic run(input int c, input logic [31:0] s, input logic [47:0] v, input int inc);
    int n = 1 + $urandom % 8;
    logic [31:0] p = $urandom & 32'hffff;
    // Load the disabled selection first, so the edge history settles before counting.
    bus(1'b1, {c[1:0], 2'h0}, s);
    bus(1'b1, {c[1:0], 2'h1}, p);
    bus(1'b1, {c[1:0], 2'h2}, 32'h0);
    bus(1'b1, {c[1:0], 2'h0}, s | 32'h0040_0000);
    repeat (n) begin
      vec <= v;
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (4) @(posedge clk);
    end
    bus(1'b1, {c[1:0], 2'h0}, s);
    bus_rd({c[1:0], 2'h0}, s);
    bus_rd({c[1:0], 2'h1}, p + n * inc);
    bus_rd({c[1:0], 2'h2}, 32'h0);
    bus_rd({c[1:0], 2'h3}, 32'h0);
    tno++;
    $display("test %0d done, counter %0d select %h", tno, c, s);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence: reset, reset values, then 64 burst tests over the selections.
  initial begin
    seed = $urandom(32'h2f98);
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    for (int c = 0; c < 4; c++) bus_rd({c[1:0], 2'h0}, 32'h0);
    for (int k = 0; k < 3; k++) run(1, 32'h163, b << k, 2);
    run(0, 32'h263, b << 3, 2);
    run(2, 32'h163, b, 0);
    run(3, 32'h263, b << 3, 0);
    run(1, 32'h16c, b << 4, 2);
    for (int k = 0; k < 4; k++) run(k, 32'h80 | (k + 1) << 8, b << (5 + k), k == 1 ? 1 : 2);
    run(0, 32'h182, b << 9, 2);
    run(1, 32'h185, b << 10, 2);
    run(2, 32'h285, b << 11, 2);
    for (int k = 0; k < 4; k++) run(k, 32'h87 | 1 << (k + 8), b << (12 + k), 2);
    run(0, 32'hf87, 48'h5 << 12, 2);
    for (int k = 0; k < 7; k++) run(k, 32'h88 | 1 << (k + 8), 48'h1_0000 | b << (18 + k), 2);
    run(1, 32'h788, 48'h1_0000 | b << 20, 2);
    run(2, 32'h3088, 48'h1_0000 | b << 22, 2);
    run(3, 32'h7f88, 48'h1_0000 | b << 21, 2);
    run(0, 32'h188, 48'h1_0000 | b << 21, 0);
    for (int k = 0; k < 7; k++) run(k, 32'h89 | 1 << (k + 8), 48'h3_0000 | b << (18 + k), k % 3 == 1 ? 0 : 2);
    run(1, 32'h7f89, 48'h1_0000 | b << 23, 0);
    for (int k = 0; k < 8; k++) run(k, 32'ha2 | 1 << (k + 8), b << (25 + k), k == 3 ? 0 : 2);
    run(2, 32'h8a2, b << 33, 2);
    run(3, 32'h1a6, b << 35, 2);
    run(0, 32'h1a7, b << 36, 2);
    run(1, 32'h1a8, 48'h5 << 37, 10);
    run(2, 32'h0300_01a8, 48'h5 << 37, 2);
    run(3, 32'h1ae, b << 40, 2);
    run(0, 32'h40b0, b << 41, 2);
    for (int k = 0; k < 6; k++) run(k, 32'hb1 | 1 << (k + 8), b << (42 + k), 2);
    run(1, 32'h3fb1, 48'h23 << 42, 6);
    run(2, 32'h1fb1, 48'h23 << 42, 4);
    run(3, 32'h0100_3fb1, 48'h23 << 42, 2);
    run(0, 32'h1fb1, b << 47, 0);
    run(1, 32'h0184_3fb1, 48'h23 << 42, 1);
    report_and_stop();
  end

  // Watchdog: the sequence needs well under 8000 cycles.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
endmodule // tb
